/* File: pkg/sla_pkg.sv */
// Constants, register map and state encoding of the sleep level arbiter.
// Assumes a 100 MHz system clock; all timing counts derive from it.
package sla_pkg;

    localparam int unsigned CLK_PERIOD_NS    = 10;
    // Deep sleep to active transition time, treated as a least time
    localparam int unsigned DEEP_WAKE_NS     = 25000;
    localparam int unsigned DEEP_WAKE_CYC    = (DEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Hibernation exit time, treated as a least time
    localparam int unsigned HIB_WAKE_NS      = 2000000;
    localparam int unsigned HIB_WAKE_CYC_DEF = (HIB_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef logic [1:0] sla_level_t;

    localparam sla_level_t LVL_NONE      = 2'h0;
    localparam sla_level_t LVL_NORMAL    = 2'h1;
    localparam sla_level_t LVL_DEEP      = 2'h2;
    localparam sla_level_t SYS_LVL_RST   = LVL_NORMAL;
    localparam sla_level_t PIPE_LVL_RST  = LVL_DEEP;
    localparam sla_level_t PWM_CAP       = LVL_NORMAL;
    localparam logic       PWM_EN_RST    = 1'b0;

    localparam int unsigned AVS_AW       = 5;
    localparam int unsigned AVS_DW       = 32;
    localparam logic [AVS_AW-1:0] REG_SYS_SLEEP  = 5'h00;
    localparam logic [AVS_AW-1:0] REG_PIPE_SLEEP = 5'h04;
    localparam logic [AVS_AW-1:0] REG_PWM_MODE   = 5'h08;
    localparam logic [AVS_AW-1:0] REG_STATUS     = 5'h0c;

    // Status register field positions
    localparam int unsigned ST_LVL_LSB   = 0;
    localparam int unsigned ST_STATE_LSB = 2;
    localparam int unsigned ST_CAUSE_BIT = 5;
    localparam int unsigned ST_SHDN_BIT  = 6;
    localparam int unsigned ST_INH_BIT   = 7;
    localparam int unsigned ST_PIPE_BIT  = 8;

    typedef enum logic [2:0] {
        SLA_ACTIVE = 3'b000,
        SLA_SLEEP  = 3'b001,
        SLA_DEEP   = 3'b010,
        SLA_WAKE   = 3'b011,
        SLA_HIBER  = 3'b100,
        SLA_BOOT   = 3'b101
    } sla_state_t;

endpackage : sla_pkg

/* File: rtl/sla_sync.sv */
// Two-flop synchroniser for asynchronous pins.
// Assumes the inputs are quasi-static compared with the clock.
`timescale 1ns/1ps
module sla_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : sla_sync

/* File: rtl/sla_sleep_level_arbiter.sv */
// Power state arbiter: picks active, sleep, deep sleep or hibernation
// from two host pins, software limits and the pipe and PWM state.
// Assumes an Avalon-MM master on i_clk_sys; pins are asynchronous.
`timescale 1ns/1ps

// Summary of operation
// RULE1: Shutdown request asserted forces hibernation above all else.
// RULE2: Sleep-inhibit asserted without shutdown keeps the device active.
// RULE3: Otherwise effective level is the minimum of applicable limits (0,1,2).
// RULE4: Pipe limit counts only while connected and in pipe data mode.
// RULE5: PWM enabled caps the effective level at normal sleep.
// RULE6: System limit resets to normal sleep, level 1.
// RULE7: Pipe limit resets to deep sleep, level 2.
// RULE8: Priority and minimum selection are fixed, not configurable.
// RULE9: Sleep-inhibit is active low; low means never sleep except shutdown.
// RULE10: Shutdown is active low; disables radio, CPU and peripherals.
// RULE11: Hibernation is left only by releasing the shutdown request.
// RULE12: Hibernation exit acts as chip reset but keeps RAM contents.
// RULE13: After shutdown release a boot event reports hibernation cause.
// RULE14: Sleep indicator is low while CPU awake, high while asleep.
// RULE15: Shutdown immediately drops any radio connection.
// RULE16: Host should disconnect before shutdown for a clean end.
// RULE17: Host should hold sleep-inhibit around its UART transmissions.
// RULE18: With deep sleep allowed host sends dummy byte or uses inhibit.
// RULE19: Deep sleep stops CPU, radio, UART, fast clocks; wake takes 25 us.
// RULE20: Effective level is recomputed whenever any input changes.
module sla_sleep_level_arbiter
    import sla_pkg::*;
#(
    parameter int unsigned HIB_WAKE_CYC = sla_pkg::HIB_WAKE_CYC_DEF
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_shutdown_request_n,
    input  wire logic                       i_sleep_inhibit_n,
    input  wire logic                       i_link_connected,
    input  wire logic                       i_pipe_data_mode,
    input  wire logic [sla_pkg::AVS_AW-1:0] i_avs_address,
    input  wire logic                       i_avs_read,
    input  wire logic                       i_avs_write,
    input  wire logic [sla_pkg::AVS_DW-1:0] i_avs_writedata,
    input  wire logic [3:0]                 i_avs_byteenable,
    output logic      [sla_pkg::AVS_DW-1:0] o_avs_readdata,
    output logic                            o_avs_waitrequest,
    output logic                            o_cpu_sleep_indicator,
    output logic                            o_cpu_run,
    output logic                            o_radio_run,
    output logic                            o_periph_run,
    output logic                            o_hs_clk_en,
    output logic                            o_chip_reset,
    output logic                            o_radio_abort,
    output logic                            o_boot_event,
    output logic                            o_boot_cause
);
    import sla_pkg::*;

    localparam int unsigned CNT_W = $clog2(HIB_WAKE_CYC + 1);

    if (HIB_WAKE_CYC < 1 || HIB_WAKE_CYC < DEEP_WAKE_CYC) begin : g_chk
        $error("HIB_WAKE_CYC must be at least 1 and not below DEEP_WAKE_CYC");
    end

    function automatic sla_level_t lvl_min(input sla_level_t a, input sla_level_t b);
        lvl_min = (a < b) ? a : b;
    endfunction : lvl_min

    logic [1:0]  pins_s;
    logic        shdn_n_s;
    logic        inh_n_s;
    sla_level_t  sys_lvl_q;
    sla_level_t  pipe_lvl_q;
    logic        pwm_en_q;
    sla_level_t  lvl_eff;
    logic        pipe_open;
    sla_state_t  state_q;
    sla_state_t  state_d;
    logic [CNT_W-1:0] cnt_q;
    logic        boot_cause_q;

    sla_sync #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_shutdown_request_n, i_sleep_inhibit_n}),
        .o_sync    (pins_s)
    );
    assign shdn_n_s = pins_s[1];
    assign inh_n_s  = pins_s[0];

    assign pipe_open = i_link_connected && i_pipe_data_mode; // [RULE4]

    // Pure combinational arbitration; link and pipe mode changes are seen at once, the inhibit pin two cycles later
    always_comb begin // [RULE20]
        lvl_eff = sys_lvl_q; // [RULE3] [RULE8]
        if (pipe_open) begin
            lvl_eff = lvl_min(lvl_eff, pipe_lvl_q); // [RULE4]
        end
        if (pwm_en_q) begin
            lvl_eff = lvl_min(lvl_eff, PWM_CAP); // [RULE5]
        end
        if (!inh_n_s) begin
            lvl_eff = LVL_NONE; // [RULE2] [RULE9]
        end
    end

    // Avalon-MM slave: fixed one wait state on every access
    logic        req;
    logic        wr_go;
    logic [AVS_DW-1:0] rd_mux;

    assign req   = i_avs_read || i_avs_write;
    assign wr_go = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];

    always_comb begin
        rd_mux = '0;
        case (i_avs_address)
            REG_SYS_SLEEP:  rd_mux[1:0] = sys_lvl_q;
            REG_PIPE_SLEEP: rd_mux[1:0] = pipe_lvl_q;
            REG_PWM_MODE:   rd_mux[0]   = pwm_en_q;
            REG_STATUS: begin
                rd_mux[ST_LVL_LSB +: 2]   = lvl_eff;
                rd_mux[ST_STATE_LSB +: 3] = state_q;
                rd_mux[ST_CAUSE_BIT]      = boot_cause_q;
                rd_mux[ST_SHDN_BIT]       = shdn_n_s;
                rd_mux[ST_INH_BIT]        = inh_n_s;
                rd_mux[ST_PIPE_BIT]       = pipe_open;
            end
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
        end else begin
            o_avs_waitrequest <= !(req && o_avs_waitrequest);
            if (req && o_avs_waitrequest) begin
                o_avs_readdata <= i_avs_read ? rd_mux : '0;
            end
        end
    end

    // Limits sit in retained RAM, so hibernation does not clear them
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_lvl_q  <= SYS_LVL_RST; // [RULE6]
            pipe_lvl_q <= PIPE_LVL_RST; // [RULE7]
            pwm_en_q   <= PWM_EN_RST;
        end else if (wr_go) begin
            // Level 3 is not a valid level; such writes are dropped
            if (i_avs_address == REG_SYS_SLEEP && i_avs_writedata[1:0] <= LVL_DEEP) begin
                sys_lvl_q <= i_avs_writedata[1:0];
            end
            if (i_avs_address == REG_PIPE_SLEEP && i_avs_writedata[1:0] <= LVL_DEEP) begin
                pipe_lvl_q <= i_avs_writedata[1:0];
            end
            if (i_avs_address == REG_PWM_MODE) begin
                pwm_en_q <= i_avs_writedata[0];
            end
        end
    end

    // Power state sequencing
    always_comb begin
        state_d = state_q;
        if (!shdn_n_s) begin
            state_d = SLA_HIBER; // [RULE1] [RULE10]
        end else begin
            case (state_q)
                SLA_ACTIVE: begin
                    if (lvl_eff == LVL_NORMAL) begin
                        state_d = SLA_SLEEP;
                    end else if (lvl_eff == LVL_DEEP) begin
                        state_d = SLA_DEEP;
                    end
                end
                SLA_SLEEP: begin
                    if (lvl_eff == LVL_NONE) begin
                        state_d = SLA_ACTIVE;
                    end else if (lvl_eff == LVL_DEEP) begin
                        state_d = SLA_DEEP;
                    end
                end
                SLA_DEEP: begin
                    if (lvl_eff != LVL_DEEP) begin
                        state_d = SLA_WAKE; // [RULE19]
                    end
                end
                SLA_WAKE: begin
                    if (cnt_q == '0) begin
                        state_d = SLA_ACTIVE;
                    end
                end
                SLA_HIBER:  state_d = SLA_BOOT; // [RULE11]
                SLA_BOOT: begin
                    if (cnt_q == '0) begin
                        state_d = SLA_ACTIVE;
                    end
                end
                default:    state_d = SLA_BOOT;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= SLA_BOOT;
        end else begin
            state_q <= state_d;
        end
    end

    // Shared down counter for deep wake and hibernation exit
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else if (state_q == SLA_DEEP && state_d == SLA_WAKE) begin
            cnt_q <= CNT_W'(DEEP_WAKE_CYC - 1); // [RULE19]
        end else if (state_q == SLA_HIBER && state_d == SLA_BOOT) begin
            cnt_q <= CNT_W'(HIB_WAKE_CYC - 1); // [RULE12]
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Power-on boot reports cause 0, hibernation exit reports cause 1
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot_cause_q <= 1'b0;
            o_boot_event <= 1'b0;
            o_boot_cause <= 1'b0;
        end else begin
            if (state_q == SLA_HIBER && state_d == SLA_BOOT) begin
                boot_cause_q <= 1'b1;
            end else if (state_q == SLA_ACTIVE) begin
                boot_cause_q <= 1'b0;
            end
            o_boot_event <= (state_q == SLA_BOOT) && (state_d == SLA_ACTIVE); // [RULE13]
            if ((state_q == SLA_BOOT) && (state_d == SLA_ACTIVE)) begin
                o_boot_cause <= boot_cause_q; // [RULE13]
            end
        end
    end

    // Domain enables, registered from the next state
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_sleep_indicator <= 1'b1;
            o_cpu_run             <= 1'b0;
            o_radio_run           <= 1'b0;
            o_periph_run          <= 1'b0;
            o_hs_clk_en           <= 1'b0;
            o_chip_reset          <= 1'b1;
        end else begin
            o_cpu_sleep_indicator <= (state_d != SLA_ACTIVE); // [RULE14]
            o_cpu_run             <= (state_d == SLA_ACTIVE);
            o_radio_run           <= (state_d == SLA_ACTIVE); // [RULE10]
            o_periph_run          <= (state_d == SLA_ACTIVE) || (state_d == SLA_SLEEP);
            o_hs_clk_en           <= (state_d != SLA_DEEP) && (state_d != SLA_HIBER); // [RULE19]
            o_chip_reset          <= (state_d == SLA_BOOT) || (state_d == SLA_HIBER); // [RULE12]
        end
    end

    // No orderly disconnect: the link is cut the moment shutdown arrives
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_radio_abort <= 1'b0;
        end else begin
            o_radio_abort <= (state_q != SLA_HIBER) && !shdn_n_s && i_link_connected; // [RULE15]
        end
    end

    property p_shdn_hiber;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !shdn_n_s |=> (state_q == SLA_HIBER) && !o_cpu_run && !o_radio_run && !o_periph_run;
    endproperty
    a_shdn_hiber: assert property (p_shdn_hiber) else $error("shutdown did not hibernate"); // [RULE1]

    property p_inhibit_active;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        shdn_n_s && !inh_n_s && state_q == SLA_ACTIVE |=> state_q == SLA_ACTIVE && !o_cpu_sleep_indicator;
    endproperty
    a_inhibit_active: assert property (p_inhibit_active) else $error("slept while inhibited"); // [RULE2]

    property p_min_level;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        inh_n_s |-> lvl_eff <= sys_lvl_q && (lvl_eff == sys_lvl_q || lvl_eff == pipe_lvl_q || lvl_eff == PWM_CAP);
    endproperty
    a_min_level: assert property (p_min_level) else $error("effective level not a minimum"); // [RULE3]

    property p_pipe_closed;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        inh_n_s && !pipe_open && !pwm_en_q |-> lvl_eff == sys_lvl_q;
    endproperty
    a_pipe_closed: assert property (p_pipe_closed) else $error("pipe limit used while closed"); // [RULE4]

    property p_pwm_cap;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        pwm_en_q |-> lvl_eff <= PWM_CAP;
    endproperty
    a_pwm_cap: assert property (p_pwm_cap) else $error("PWM cap exceeded"); // [RULE5]

    property p_hiber_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q == SLA_HIBER && !shdn_n_s |=> state_q == SLA_HIBER && o_chip_reset;
    endproperty
    a_hiber_hold: assert property (p_hiber_hold) else $error("left hibernation early"); // [RULE11]

    property p_boot_event;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q == SLA_BOOT && cnt_q == '0 && shdn_n_s && $past(state_q) == SLA_BOOT
        |=> o_boot_event && o_boot_cause == $past(boot_cause_q);
    endproperty
    a_boot_event: assert property (p_boot_event) else $error("boot event missing"); // [RULE13]

    property p_indicator;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_cpu_sleep_indicator == (state_q != SLA_ACTIVE) && o_cpu_run == !o_cpu_sleep_indicator;
    endproperty
    a_indicator: assert property (p_indicator) else $error("sleep indicator wrong"); // [RULE14]

    property p_abort;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q != SLA_HIBER && !shdn_n_s && i_link_connected |=> o_radio_abort ##1 !o_radio_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("radio not aborted"); // [RULE15]

    property p_deep_wake;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q == SLA_DEEP && state_d == SLA_WAKE |=> cnt_q == CNT_W'(DEEP_WAKE_CYC - 1) && o_hs_clk_en;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("deep wake timing wrong"); // [RULE19]

endmodule : sla_sleep_level_arbiter

/* File: bench/sla_host_model.sv */
// Host controller model: drives the shutdown and sleep-inhibit pins.
// Assumes the bench raises requests by non-blocking assignment after an edge.
`timescale 1ns/1ps
module sla_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_hibernate_req,
    input  wire logic i_uart_tx_busy,
    output logic      o_disconnect_cmd,
    output logic      o_shutdown_request_n,
    output logic      o_sleep_inhibit_n
);
    logic disc_sent_q;

    // Disconnect goes out one cycle ahead of the pin for a clean link end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_disconnect_cmd     <= 1'b0;
            disc_sent_q          <= 1'b0;
            o_shutdown_request_n <= 1'b1;
        end else begin
            o_disconnect_cmd     <= i_hibernate_req && !disc_sent_q;
            disc_sent_q          <= i_hibernate_req;
            o_shutdown_request_n <= !(i_hibernate_req && disc_sent_q);
        end
    end

    // Inhibit only around transmissions, so deep sleep stays usable otherwise
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sleep_inhibit_n <= 1'b1;
        end else begin
            o_sleep_inhibit_n <= !i_uart_tx_busy;
        end
    end
endmodule : sla_host_model

/* File: bench/tb_top.sv */
// Self-checking bench for the sleep level arbiter.
// Assumes the host model on the pins and an Avalon master in the bench.
`timescale 1ns/1ps
module tb_top;
    import sla_pkg::*;
    localparam int unsigned HIB_CYC = 2500;

    logic        clk_sys;
    logic        rst_n;
    logic        link_connected;
    logic        pipe_data_mode;
    logic        hib_req;
    logic        tx_busy;
    logic        avs_read;
    logic        avs_write;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic        waitrequest;
    logic        sleep_ind;
    logic        cpu_run;
    logic        radio_run;
    logic        periph_run;
    logic        hs_clk_en;
    logic        chip_reset;
    logic        radio_abort;
    logic        boot_event;
    logic        boot_cause;
    wire logic   shutdown_n;
    wire logic   inhibit_n;
    wire logic   disc_cmd;
    int          fails;
    int          comparisons;
    logic [8:0]  tbl [8] = '{9'b10_10_0_1_1_10, 9'b10_01_0_1_1_01, 9'b10_00_0_1_0_10, 9'b10_00_0_0_1_10,
                             9'b01_10_0_1_1_01, 9'b10_10_1_0_0_01, 9'b00_10_1_0_0_00, 9'b10_00_1_1_1_00};

    sla_host_model host (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_hibernate_req(hib_req),
        .i_uart_tx_busy(tx_busy), .o_disconnect_cmd(disc_cmd), .o_shutdown_request_n(shutdown_n),
        .o_sleep_inhibit_n(inhibit_n));

    sla_sleep_level_arbiter #(.HIB_WAKE_CYC(HIB_CYC)) dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .i_shutdown_request_n(shutdown_n), .i_sleep_inhibit_n(inhibit_n), .i_link_connected(link_connected),
        .i_pipe_data_mode(pipe_data_mode), .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
        .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest), .o_cpu_sleep_indicator(sleep_ind),
        .o_cpu_run(cpu_run), .o_radio_run(radio_run), .o_periph_run(periph_run), .o_hs_clk_en(hs_clk_en),
        .o_chip_reset(chip_reset), .o_radio_abort(radio_abort), .o_boot_event(boot_event),
        .o_boot_cause(boot_cause));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic timeout_if(input bit hit);
        if (hit) begin
            fails++;
            $display("mismatch wait expected done seen timeout");
            complete_run();
        end
    endtask : timeout_if

    // One request held until waitrequest is sampled low; read data taken there
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk_sys);
        while (waitrequest !== 1'b0) begin
            timeout_if(n > 50);
            n++;
            @(posedge clk_sys);
        end
        rd = readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic t_reset;
        int n;
        n = 0;
        while (boot_event !== 1'b1) begin
            timeout_if(n > 20);
            n++;
            @(posedge clk_sys);
        end
        check("power-on boot cause", 32'h0, 32'(boot_cause));
        bus(1'b0, REG_SYS_SLEEP, 32'h0);
        check("system level reset", 32'h1, rd);
        bus(1'b0, REG_PIPE_SLEEP, 32'h0);
        check("pipe level reset", 32'h2, rd);
        bus(1'b0, 5'h10, 32'h0);
        check("unmapped read", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset

    task automatic t_levels;
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, REG_SYS_SLEEP, 32'(tbl[i][8:7]));
            bus(1'b1, REG_PIPE_SLEEP, 32'(tbl[i][6:5]));
            bus(1'b1, REG_PWM_MODE, 32'(tbl[i][4]));
            link_connected <= tbl[i][3];
            pipe_data_mode <= tbl[i][2];
            bus(1'b0, REG_STATUS, 32'h0);
            check("effective level", 32'(tbl[i][1:0]), 32'(rd[1:0]));
        end
        bus(1'b1, REG_SYS_SLEEP, 32'h3);
        bus(1'b0, REG_SYS_SLEEP, 32'h0);
        check("level 3 refused", 32'h2, rd);
        // Byte lane 0 carries the level, so without it the write is dropped
        avs_byteenable <= 4'he;
        bus(1'b1, REG_SYS_SLEEP, 32'h1);
        avs_byteenable <= 4'hf;
        bus(1'b0, REG_SYS_SLEEP, 32'h0);
        check("byte 0 disabled write", 32'h2, rd);
        $display("test levels done");
    endtask : t_levels

    task automatic t_inhibit;
        bus(1'b1, REG_SYS_SLEEP, 32'h1);
        bus(1'b1, REG_PWM_MODE, 32'h0);
        link_connected <= 1'b0;
        repeat (3000) @(posedge clk_sys);
        check("indicator asleep", 32'h1, 32'(sleep_ind));
        tx_busy <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("indicator awake", 32'h0, 32'(sleep_ind));
        check("cpu runs", 32'h1, 32'(cpu_run));
        bus(1'b0, REG_STATUS, 32'h0);
        check("inhibited level", 32'h0, 32'(rd[1:0]));
        tx_busy <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check("indicator asleep again", 32'h1, 32'(sleep_ind));
        $display("test inhibit done");
    endtask : t_inhibit

    task automatic t_deep;
        int n;
        bus(1'b1, REG_SYS_SLEEP, 32'h2);
        repeat (5) @(posedge clk_sys);
        check("deep clocks off", 32'h0, 32'(hs_clk_en));
        bus(1'b0, REG_STATUS, 32'h0);
        check("deep state", 32'(SLA_DEEP), 32'(rd[4:2]));
        tx_busy <= 1'b1;
        n = 0;
        while (cpu_run !== 1'b1) begin
            timeout_if(n > 3000);
            n++;
            @(posedge clk_sys);
        end
        // Host, sync and state registers add a few cycles on top of the wake time
        check("deep wake time", 32'h1, 32'(n >= DEEP_WAKE_CYC && n <= DEEP_WAKE_CYC + 8));
        tx_busy <= 1'b0;
        $display("test deep done");
    endtask : t_deep

    task automatic t_shutdown;
        int n;
        int aborts;
        int discs;
        aborts = 0;
        discs  = 0;
        link_connected <= 1'b1;
        pipe_data_mode <= 1'b1;
        tx_busy        <= 1'b1;
        hib_req        <= 1'b1;
        for (n = 0; n < 12; n++) begin
            @(posedge clk_sys);
            aborts += int'(radio_abort === 1'b1);
            discs  += int'(disc_cmd === 1'b1 && shutdown_n === 1'b1);
        end
        check("radio abort pulses", 32'h1, 32'(aborts));
        check("disconnect ahead of shutdown", 32'h1, 32'(discs));
        check("chip reset held", 32'h1, 32'(chip_reset));
        check("run outputs off", 32'h0, 32'({cpu_run, radio_run, periph_run}));
        tx_busy <= 1'b0;
        repeat (50) @(posedge clk_sys);
        check("still hibernating", 32'h1, 32'(chip_reset));
        hib_req <= 1'b0;
        n = 0;
        while (boot_event !== 1'b1) begin
            timeout_if(n > 4000);
            n++;
            @(posedge clk_sys);
        end
        check("hibernation boot cause", 32'h1, 32'(boot_cause));
        check("boot length", 32'h1, 32'(n >= HIB_CYC && n <= HIB_CYC + 8));
        bus(1'b0, REG_SYS_SLEEP, 32'h0);
        check("limit kept", 32'h2, rd);
        $display("test shutdown done");
    endtask : t_shutdown

    initial begin
        fails          = 0;
        comparisons    = 0;
        rst_n          = 1'b0;
        link_connected = 1'b0;
        pipe_data_mode = 1'b0;
        hib_req        = 1'b0;
        tx_busy        = 1'b0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_address    = 5'h00;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_levels();
        t_inhibit();
        t_deep();
        t_shutdown();
        complete_run();
    end
endmodule : tb_top
